// ===== rtl/status_diag_bank.sv
// Read-only diagnostic and latched error status registers on the MPU port
`include "status_diag_defs.svh"
`default_nettype none
// Behaviour
// - Residual is 16 bits, high byte at 0x20
// - Residual refreshes on master receive frame interrupt
// - Mask readback returns last mask write
// - Phase error is signed byte, 0x80..0x7f
// - Phase error updates with master frame interrupt
// - Count PCM clocks sync rise to marker
// - Zero count means one clock of phase
// - Every write byte lands in shadow register
// - Reading error register clears it
// - Error bits latch individually until cleared
// - Disabled source raises no interrupt request
// - Bits 0..2 flag transmit channels
// - Bits 3..5 flag receive channels
// - Bit 6 flags loop phase limit
// - Error requests are OR of enabled sources
module status_diag_bank
  import status_diag_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // MPU port
  input wire mpu_req_type mpu_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Clock recovery loop
  input wire loop_sample_type loop_sample_in,
  input wire logic master_receive_frame_interrupt_in,
  input wire logic loop_error_enable_in,
  // Channel error events and enables
  input wire chan_err_type chan_err_event_in,
  input wire chan_err_type chan_err_enable_in,
  // Multiframe phase measurement
  input wire logic pcm_transmit_clock_in,
  input wire logic transmit_multiframe_sync_in,
  input wire logic receive_multiframe_sync_out_in,
  input wire logic phase_reference_select_in,
  input wire logic internal_multiframe_marker_in,
  // Error interrupt requests
  output logic tx_err_request_out,
  output logic rx_err_request_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic at_limit(input logic [7:0] err);
    at_limit = (err == `PHASE_ERR_MIN) || (err == `PHASE_ERR_MAX);
  endfunction : at_limit

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] residual_reg;
  logic [7:0] phase_err_reg;
  logic [7:0] mask_reg;
  logic [7:0] shadow_reg;
  logic [6:0] errors_reg;
  logic [6:0] errors_next;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic tx_req_reg;
  logic rx_req_reg;
  logic [12:0] sync_phase;
  logic sync_phase_done;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire logic rd_errors = mpu_req_in.rd && hit(mpu_req_in.addr, `ERROR_SOURCES_ADDR);
  wire logic wr_mask = mpu_req_in.wr && hit(mpu_req_in.addr, `MASK_WRITE_ADDR);
  wire logic loop_limit_error = master_receive_frame_interrupt_in
                                && at_limit(loop_sample_in.phase_err);
  // Latch follows the raw event so software can still see a masked source
  wire logic [6:0] error_sets = {loop_limit_error, chan_err_event_in.rx,
                                 chan_err_event_in.tx};
  wire logic [2:0] tx_enabled = chan_err_event_in.tx & chan_err_enable_in.tx;
  wire logic [2:0] rx_enabled = chan_err_event_in.rx & chan_err_enable_in.rx;
  wire logic loop_enabled = loop_limit_error && loop_error_enable_in;
  wire logic tx_req_next = |tx_enabled;
  wire logic rx_req_next = (|rx_enabled) || loop_enabled;

  // Set beats the read-clear in the same cycle
  assign errors_next = (rd_errors ? 7'h00 : errors_reg) | error_sets;

  wire logic [7:0] rd_mux =
    hit(mpu_req_in.addr, `RESIDUAL_HIGH_ADDR) ? residual_reg[15:8] :
    hit(mpu_req_in.addr, `RESIDUAL_LOW_ADDR) ? residual_reg[7:0] :
    hit(mpu_req_in.addr, `MASK_READBACK_ADDR) ? mask_reg :
    hit(mpu_req_in.addr, `LOOP_PHASE_ERROR_ADDR) ? phase_err_reg :
    hit(mpu_req_in.addr, `SYNC_PHASE_LOW_ADDR) ? sync_phase[7:0] :
    hit(mpu_req_in.addr, `SYNC_PHASE_HIGH_ADDR) ? {3'h0, sync_phase[12:8]} :
    hit(mpu_req_in.addr, `WRITE_SHADOW_ADDR) ? shadow_reg :
    hit(mpu_req_in.addr, `ERROR_SOURCES_ADDR) ? {1'b0, errors_reg} :
    `UNUSED_BYTE;

  ////////////////////////////////////////////////////////////////////////
  // Phase meter

  frame_phase_meter #(
    .PHASE_WIDTH(13)
  ) u_meter (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pcm_transmit_clock_in(pcm_transmit_clock_in),
    .transmit_multiframe_sync_in(transmit_multiframe_sync_in),
    .receive_multiframe_sync_out_in(receive_multiframe_sync_out_in),
    .phase_reference_select_in(phase_reference_select_in),
    .internal_multiframe_marker_in(internal_multiframe_marker_in),
    .phase_out(sync_phase),
    .done_out(sync_phase_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Loop snapshot, taken only at the master frame so reads stay coherent

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      residual_reg <= `RESIDUAL_RESET;
      phase_err_reg <= `BYTE_RESET;
    end
    else if (master_receive_frame_interrupt_in)
    begin
      residual_reg <= loop_sample_in.residual;
      phase_err_reg <= loop_sample_in.phase_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask copy and write shadow

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mask_reg <= `BYTE_RESET;
      shadow_reg <= `BYTE_RESET;
    end
    else
    begin
      if (wr_mask)
      begin
        mask_reg <= mpu_req_in.wdata;
      end
      if (mpu_req_in.wr)
      begin
        shadow_reg <= mpu_req_in.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error latch, read data and requests

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      errors_reg <= 7'h00;
      rd_data_reg <= `BYTE_RESET;
      rd_valid_reg <= 1'b0;
      tx_req_reg <= 1'b0;
      rx_req_reg <= 1'b0;
    end
    else
    begin
      errors_reg <= errors_next;
      rd_valid_reg <= mpu_req_in.rd;
      tx_req_reg <= tx_req_next;
      rx_req_reg <= rx_req_next;
      if (mpu_req_in.rd)
      begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign tx_err_request_out = tx_req_reg;
  assign rx_err_request_out = rx_req_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_residual_refresh : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    master_receive_frame_interrupt_in |=> residual_reg == $past(loop_sample_in.residual))
  else $error("residual not refreshed at master frame");

  chk_residual_hold : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !master_receive_frame_interrupt_in |=> $stable(residual_reg))
  else $error("residual changed outside master frame");

  chk_residual_high_read : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `RESIDUAL_HIGH_ADDR
    |=> rd_valid_out && rd_data_out == $past(residual_reg[15:8]))
  else $error("residual high byte read wrong");

  chk_phase_err_hold : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    master_receive_frame_interrupt_in
    |=> phase_err_reg == $past(loop_sample_in.phase_err)
        ##1 ($past(master_receive_frame_interrupt_in) || $stable(phase_err_reg)) [*1])
  else $error("phase error not updated with master frame");

  chk_phase_err_read : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `LOOP_PHASE_ERROR_ADDR
    |=> rd_data_out == $past(phase_err_reg))
  else $error("phase error read wrong");

  chk_mask_copy : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_mask |=> mask_reg == $past(mpu_req_in.wdata))
  else $error("mask write not copied");

  chk_mask_readback : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `MASK_READBACK_ADDR
    |=> rd_data_out == $past(mask_reg))
  else $error("mask readback differs from last mask write");

  chk_shadow_any_write : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.wr |=> shadow_reg == $past(mpu_req_in.wdata))
  else $error("shadow does not hold last write");

  chk_shadow_read : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `WRITE_SHADOW_ADDR
    |=> rd_data_out == $past(shadow_reg))
  else $error("shadow read wrong");

  chk_error_clear : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_errors && error_sets == 7'h00 |=> errors_reg == 7'h00)
  else $error("error register not cleared by read");

  chk_error_read_value : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_errors |=> rd_data_out == {1'b0, $past(errors_reg)} && !rd_data_out[7])
  else $error("error register read value wrong");

  chk_error_latch : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (error_sets != 7'h00) ##1 !rd_errors [*2]
    |-> (errors_reg & $past(error_sets, 2)) == $past(error_sets, 2))
  else $error("error bit lost before clear");

  chk_set_beats_clear : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_errors && chan_err_event_in.tx[0] |=> errors_reg[`ERR_TX_LSB])
  else $error("set lost against read clear");

  chk_rx_field : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    chan_err_event_in.rx[2] |=> errors_reg[`ERR_RX_LSB + 2])
  else $error("receive channel three not flagged in bit 5");

  chk_loop_limit : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    master_receive_frame_interrupt_in && loop_sample_in.phase_err == 8'h7f
    |=> errors_reg[`ERR_LOOP_BIT])
  else $error("loop limit not flagged");

  chk_tx_field : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    chan_err_event_in.tx[1] |=> errors_reg[`ERR_TX_LSB + 1])
  else $error("transmit channel two not flagged in bit 1");

  chk_disabled_quiet : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (chan_err_event_in.tx & ~chan_err_enable_in.tx) != 3'h0
    && (chan_err_event_in.tx & chan_err_enable_in.tx) == 3'h0 |=> !tx_err_request_out)
  else $error("disabled transmit source raised request");

  chk_rx_quiet : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (chan_err_event_in.rx & ~chan_err_enable_in.rx) != 3'h0
    && (chan_err_event_in.rx & chan_err_enable_in.rx) == 3'h0 && !loop_limit_error
    |=> !rx_err_request_out)
  else $error("disabled receive source raised request");

  chk_rx_request : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (chan_err_event_in.rx[1] && chan_err_enable_in.rx[1])
    || (loop_limit_error && loop_error_enable_in)
    |=> rx_err_request_out)
  else $error("enabled receive error raised no request");

  chk_tx_request : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    tx_err_request_out |-> $past(|(chan_err_event_in.tx & chan_err_enable_in.tx)))
  else $error("transmit request without enabled channel error");

  chk_phase_high_zero : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `SYNC_PHASE_HIGH_ADDR
    |=> rd_data_out[7:5] == 3'h0 && rd_data_out[4:0] == $past(sync_phase[12:8]))
  else $error("phase high byte read wrong");

  chk_phase_done : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    sync_phase_done |-> $past(internal_multiframe_marker_in))
  else $error("phase result without marker");

  chk_phase_one_cycle : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !sync_phase_done |-> $stable(sync_phase))
  else $error("phase result changed without marker");

  cov_error_read : cover property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (error_sets != 7'h00) ##[1:20] rd_errors);

  cov_master_frame : cover property (
    @(posedge clk_sys_in) disable iff (rst_in)
    master_receive_frame_interrupt_in ##1 mpu_req_in.rd);

  cov_phase_done : cover property (
    @(posedge clk_sys_in) disable iff (rst_in)
    sync_phase_done);

  cov_set_on_clear : cover property (
    @(posedge clk_sys_in) disable iff (rst_in)
    rd_errors && error_sets != 7'h00);

  cov_phase_high : cover property (
    @(posedge clk_sys_in) disable iff (rst_in)
    mpu_req_in.rd && mpu_req_in.addr == `SYNC_PHASE_HIGH_ADDR && sync_phase[12:8] != 5'h00);

endmodule : status_diag_bank
`default_nettype wire

// ===== rtl/status_diag_defs.svh
// Offsets, field positions, reset values and limits of the status bank
`ifndef STATUS_DIAG_DEFS_SVH
`define STATUS_DIAG_DEFS_SVH

// Register offsets on the MPU port
`define RESIDUAL_HIGH_ADDR 8'h20
`define RESIDUAL_LOW_ADDR 8'h28
`define MASK_READBACK_ADDR 8'h30
`define LOOP_PHASE_ERROR_ADDR 8'h38
`define SYNC_PHASE_LOW_ADDR 8'h39
`define SYNC_PHASE_HIGH_ADDR 8'h3a
`define WRITE_SHADOW_ADDR 8'h3b
`define ERROR_SOURCES_ADDR 8'h3c
`define MASK_WRITE_ADDR 8'heb

// Error source field positions
`define ERR_TX_LSB 0
`define ERR_RX_LSB 3
`define ERR_LOOP_BIT 6

// Reset values and limits
`define BYTE_RESET 8'h00
`define RESIDUAL_RESET 16'h0000
`define PHASE_RESET 13'h0000
`define PHASE_MAX 13'h1fff
`define PHASE_ERR_MIN 8'h80
`define PHASE_ERR_MAX 8'h7f
`define UNUSED_BYTE 8'h00

`endif

// ===== rtl/status_diag_pkg.sv
// Types shared by the status and diagnostics bank
`default_nettype none
package status_diag_pkg;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpu_req_type;

  typedef struct packed
  {
    logic [2:0] rx;
    logic [2:0] tx;
  } chan_err_type;

  typedef struct packed
  {
    logic [15:0] residual;
    logic [7:0] phase_err;
  } loop_sample_type;

  typedef enum logic [1:0]
  {
    METER_IDLE = 2'b01,
    METER_RUN = 2'b10
  } meter_state_type;

endpackage : status_diag_pkg
`default_nettype wire

// ===== rtl/frame_phase_meter.sv
// Multiframe sync to internal marker phase counter in PCM clock cycles
`include "status_diag_defs.svh"
`default_nettype none
module frame_phase_meter
  import status_diag_pkg::*;
#(
  parameter int PHASE_WIDTH = 13
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins
  input wire logic pcm_transmit_clock_in,
  input wire logic transmit_multiframe_sync_in,
  input wire logic receive_multiframe_sync_out_in,
  // Internal
  input wire logic phase_reference_select_in,
  input wire logic internal_multiframe_marker_in,
  // Result
  output logic [PHASE_WIDTH-1:0] phase_out,
  output logic done_out
);

  if (PHASE_WIDTH != 13)
  begin : g_bad_width
    $error("frame_phase_meter serves a 13-bit phase only");
  end

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;
  logic [12:0] count_reg;
  logic [12:0] count_next;
  logic [12:0] phase_reg;
  logic done_reg;
  meter_state_type state_reg;
  meter_state_type state_next;

  ////////////////////////////////////////////////////////////////////////
  // Pins cross two flops before any edge logic
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
    end
    else
    begin
      meta_reg <= {receive_multiframe_sync_out_in, transmit_multiframe_sync_in,
                   pcm_transmit_clock_in};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire logic clk_rise = sync_reg[0] & ~prev_reg[0];
  wire logic tx_rise = sync_reg[1] & ~prev_reg[1];
  wire logic rx_rise = sync_reg[2] & ~prev_reg[2];
  wire logic ref_rise = phase_reference_select_in ? rx_rise : tx_rise;
  // Saturate so a lost marker never wraps past one multiframe
  wire logic count_full = (count_reg == `PHASE_MAX);

  ////////////////////////////////////////////////////////////////////////
  // Count PCM clock edges between reference and marker
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      METER_IDLE:
      begin
        if (ref_rise)
        begin
          state_next = METER_RUN;
          count_next = 13'h0000;
        end
      end
      METER_RUN:
      begin
        if (internal_multiframe_marker_in)
        begin
          state_next = ref_rise ? METER_RUN : METER_IDLE;
          count_next = 13'h0000;
        end
        else if (clk_rise && !count_full)
        begin
          count_next = count_reg + 13'h0001;
        end
      end
      default:
      begin
        state_next = METER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_reg <= METER_IDLE;
      count_reg <= `PHASE_RESET;
      phase_reg <= `PHASE_RESET;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      done_reg <= (state_reg == METER_RUN) && internal_multiframe_marker_in;
      if ((state_reg == METER_RUN) && internal_multiframe_marker_in)
      begin
        // Zero stands for one elapsed cycle
        phase_reg <= (count_reg == 13'h0000) ? 13'h0000 : count_reg - 13'h0001;
      end
    end
  end

  chk_zero_is_one : assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_reg == METER_RUN) && internal_multiframe_marker_in && (count_reg == 13'h0001)
    |=> phase_reg == 13'h0000)
  else $error("one counted cycle not reported as zero");

  assign phase_out = phase_reg;
  assign done_out = done_reg;

endmodule : frame_phase_meter
`default_nettype wire

// ===== sim/status_diag_bank_tb_top.sv
// Self-checking bench for the status and diagnostics register bank
`include "status_diag_defs.svh"
`default_nettype none
module status_diag_bank_tb_top
  import status_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////
  logic clk_sys_in;
  logic rst_in;
  mpu_req_type mpu_req;
  logic [7:0] rd_data;
  logic rd_valid;
  loop_sample_type loop_sample;
  logic master_frame;
  logic loop_err_en;
  chan_err_type chan_event;
  chan_err_type chan_en;
  logic pcm_clk;
  logic tx_sync;
  logic rx_sync;
  logic ref_sel;
  logic marker;
  logic tx_req;
  logic rx_req;
  int bad_count;
  int samples_checked;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [7:0] a;
  logic [7:0] mask;
  logic [15:0] res;
  logic lim;
  logic [7:0] perr [4] = '{8'h80, 8'h7f, 8'h00, 8'h81};
  logic [7:0] idle_addr [9] = '{8'h20, 8'h28, 8'h30, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h55};

  status_diag_bank i_status_diag_bank (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .mpu_req_in(mpu_req),
    .rd_data_out(rd_data),
    .rd_valid_out(rd_valid),
    .loop_sample_in(loop_sample),
    .master_receive_frame_interrupt_in(master_frame),
    .loop_error_enable_in(loop_err_en),
    .chan_err_event_in(chan_event),
    .chan_err_enable_in(chan_en),
    .pcm_transmit_clock_in(pcm_clk),
    .transmit_multiframe_sync_in(tx_sync),
    .receive_multiframe_sync_out_in(rx_sync),
    .phase_reference_select_in(ref_sel),
    .internal_multiframe_marker_in(marker),
    .tx_err_request_out(tx_req),
    .rx_err_request_out(rx_req)
  );

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (exp_q.size() != 0)
      bad_count++;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Reads leave a one-cycle gap so no strobe is assigned twice in a step
  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_sys_in);
    mpu_req.rd = 1'b1;
    mpu_req.addr = addr;
    exp_q.push_back(exp);
    @(negedge clk_sys_in);
    mpu_req.rd = 1'b0;
  endtask : reg_read

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys_in);
    mpu_req.wr = 1'b1;
    mpu_req.addr = addr;
    mpu_req.wdata = data;
    @(negedge clk_sys_in);
    mpu_req.wr = 1'b0;
  endtask : reg_write

  // PCM clock kept at clk/8, well under the synchroniser limit
  task automatic pcm_rises(input int k);
    repeat (k)
    begin
      repeat (4) @(negedge clk_sys_in);
      pcm_clk = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      pcm_clk = 1'b0;
    end
  endtask : pcm_rises

  // Unselected sync rises mid-run and must not restart the count
  task automatic phase_run(input logic sel, input int k);
    logic [12:0] exp;
    ref_sel = sel;
    @(negedge clk_sys_in);
    if (sel)
      rx_sync = 1'b1;
    else
      tx_sync = 1'b1;
    pcm_rises(1);
    if (sel)
      tx_sync = 1'b1;
    else
      rx_sync = 1'b1;
    pcm_rises(k - 1);
    @(negedge clk_sys_in);
    marker = 1'b1;
    @(negedge clk_sys_in);
    marker = 1'b0;
    tx_sync = 1'b0;
    rx_sync = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    exp = 13'(k - 1);
    reg_read(`SYNC_PHASE_LOW_ADDR, exp[7:0]);
    reg_read(`SYNC_PHASE_HIGH_ADDR, {3'h0, exp[12:8]});
  endtask : phase_run

  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_in)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'(rd_data), 16'hffff);
      else
        check(16'(rd_data), 16'(exp_q.pop_front()));
    end

  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    bad_count++;
    final_report();
  end

  initial
  begin
    rst_in = 1'b1;
    mpu_req = '0;
    loop_sample = '0;
    master_frame = 1'b0;
    loop_err_en = 1'b0;
    chan_event = '0;
    chan_en = '0;
    pcm_clk = 1'b0;
    tx_sync = 1'b0;
    rx_sync = 1'b0;
    ref_sel = 1'b0;
    marker = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    mask = 8'h00;
    repeat (20) @(negedge clk_sys_in);
    rst_in = 1'b0;
    void'($urandom(17));
    // Cleared bank, unmapped address included
    foreach (idle_addr[i])
      reg_read(idle_addr[i], 8'h00);
    // Write shadow and mask copy
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      a = (i == 0 || i == 3) ? `MASK_WRITE_ADDR : 8'($urandom);
      reg_write(a, d);
      if (a == `MASK_WRITE_ADDR)
        mask = d;
      reg_read(`WRITE_SHADOW_ADDR, d);
      reg_read(`MASK_READBACK_ADDR, mask);
    end
    // Loop samples at both limits and inside them
    for (int i = 0; i < 4; i++)
    begin
      res = 16'($urandom);
      loop_sample = '{res, perr[i]};
      loop_err_en = (i != 1);
      lim = (perr[i] == `PHASE_ERR_MIN) || (perr[i] == `PHASE_ERR_MAX);
      @(negedge clk_sys_in);
      master_frame = 1'b1;
      @(negedge clk_sys_in);
      master_frame = 1'b0;
      check(16'(rx_req), 16'(lim && loop_err_en));
      loop_sample = ~loop_sample;
      reg_read(`RESIDUAL_HIGH_ADDR, res[15:8]);
      reg_read(`RESIDUAL_LOW_ADDR, res[7:0]);
      reg_read(`LOOP_PHASE_ERROR_ADDR, perr[i]);
      reg_read(`ERROR_SOURCES_ADDR, {1'b0, lim, 6'h00});
    end
    // Each channel flag, enabled and disabled
    for (int b = 0; b < 6; b++)
      for (int en = 0; en < 2; en++)
      begin
        @(negedge clk_sys_in);
        chan_en = chan_err_type'(en ? 6'h3f : ~(6'h01 << b));
        chan_event = chan_err_type'(6'h01 << b);
        @(negedge clk_sys_in);
        chan_event = '0;
        check(16'(tx_req), 16'(en == 1 && b < 3));
        check(16'(rx_req), 16'(en == 1 && b >= 3));
        reg_read(`ERROR_SOURCES_ADDR, 8'(8'h01 << b));
        reg_read(`ERROR_SOURCES_ADDR, 8'h00);
      end
    // Separate events stay latched together
    @(negedge clk_sys_in);
    chan_event = chan_err_type'(6'h01);
    @(negedge clk_sys_in);
    chan_event = chan_err_type'(6'h20);
    @(negedge clk_sys_in);
    chan_event = '0;
    repeat (10) @(negedge clk_sys_in);
    reg_read(`ERROR_SOURCES_ADDR, 8'h21);
    reg_read(`ERROR_SOURCES_ADDR, 8'h00);
    // Event lands in the read-clear cycle and must survive it
    @(negedge clk_sys_in);
    mpu_req.rd = 1'b1;
    mpu_req.addr = `ERROR_SOURCES_ADDR;
    chan_event = chan_err_type'(6'h01);
    exp_q.push_back(8'h00);
    @(negedge clk_sys_in);
    mpu_req.rd = 1'b0;
    chan_event = '0;
    reg_read(`ERROR_SOURCES_ADDR, 8'h01);
    // Multiframe phase on both references
    phase_run(1'b0, 1);
    phase_run(1'b0, 5);
    phase_run(1'b1, 3);
    phase_run(1'b1, 2 + int'($urandom % 20));
    phase_run(1'b0, 300);
    repeat (4) @(negedge clk_sys_in);
    final_report();
  end
endmodule : status_diag_bank_tb_top
`default_nettype wire
